//--- if_speedup_pkg.sv
/*
   Constants, field layouts and carrier types for the IF speed-up
   timeout and test output selector block.
   Assumes 24-bit programming words whose low three bits name the word.
*/
// Operation
// - Timeout is a 12-bit value, 0 to 4095
// - Timeout sits in word bits 14:3
// - Value 0: speed-up pin high impedance
// - Value 1: pin low, pump high gain
// - Value 2: pin low, gain bit rules
// - Value 3: pin high, gain bit rules
// - Value 4 up: timed automatic speed-up
// - On expiry: pin high impedance, low gain
// - New timeout latched at next PFD event
// - Selector is two bit pairs from words
// - Selector 0..2: high impedance, high, low
// - Selector 3..5: digital lock, open drain
// - Selector 6..8: analog lock, open drain
// - Selector 9..11: analog lock, push-pull
// - Selector 12..15: halved divider outputs
// - Gain bit: low when clear, high set
package if_speedup_pkg;

   // ==========================================================
   // Word layout
   localparam int word_width = 24;
   localparam int addr_lsb = 0;
   localparam int addr_msb = 2;
   localparam logic [2:0] addr_select_low = 3'h0;
   localparam logic [2:0] addr_gain_word = 3'h3;
   localparam logic [2:0] addr_timeout_word = 3'h5;
   localparam int timeout_lsb = 3;
   localparam int timeout_msb = 14;
   localparam int gain_bit = 19;
   localparam int select_lsb = 22;
   localparam int select_msb = 23;

   // ==========================================================
   // Reset values
   localparam logic [11:0] timeout_reset = 12'h000;
   localparam logic [1:0] select_reset = 2'h0;
   localparam logic gain_reset = 1'b0;

   // ==========================================================
   // Timeout codes
   localparam logic [11:0] toc_tristate = 12'h000;
   localparam logic [11:0] toc_manual = 12'h001;
   localparam logic [11:0] toc_gpo_low = 12'h002;
   localparam logic [11:0] toc_gpo_high = 12'h003;

   // ==========================================================
   // Selector codes
   localparam logic [3:0] sel_tristate = 4'h0;
   localparam logic [3:0] sel_high = 4'h1;
   localparam logic [3:0] sel_low = 4'h2;
   localparam logic [3:0] sel_dig_both = 4'h3;
   localparam logic [3:0] sel_dig_rf = 4'h4;
   localparam logic [3:0] sel_dig_if = 4'h5;
   localparam logic [3:0] sel_ana_od_both = 4'h6;
   localparam logic [3:0] sel_ana_od_rf = 4'h7;
   localparam logic [3:0] sel_ana_od_if = 4'h8;
   localparam logic [3:0] sel_ana_pp_both = 4'h9;
   localparam logic [3:0] sel_ana_pp_rf = 4'ha;
   localparam logic [3:0] sel_ana_pp_if = 4'hb;
   localparam logic [3:0] sel_if_ref_half = 4'hc;
   localparam logic [3:0] sel_if_fb_half = 4'hd;
   localparam logic [3:0] sel_rf_ref_half = 4'he;
   localparam logic [3:0] sel_rf_fb_half = 4'hf;

   // ==========================================================
   // Types
   typedef enum logic [2:0]
   {
      mode_tristate,
      mode_manual,
      mode_gpo_low,
      mode_gpo_high,
      mode_auto
   } timeout_mode_type;

   typedef struct packed
   {
      logic rf_digital;
      logic if_digital;
      logic rf_analog;
      logic if_analog;
   } lock_inputs_type;

   // Bit order: if_ref, if_fb, rf_ref, rf_fb from 0 upward
   typedef logic [3:0] divider_pulses_type;

   typedef struct packed
   {
      logic out;
      logic oe;
   } pin_drive_type;

   typedef struct packed
   {
      logic [11:0] pending_timeout;
      logic pending_flag;
      logic [11:0] if_timeout_count;
      logic [11:0] period_count;
      logic if_pump_gain;
      logic [1:0] select_high;
      logic [1:0] select_low;
      logic [3:0] halves;
      pin_drive_type speedup_pin;
      pin_drive_type test_pin;
      logic pump_high;
   } state_type;

endpackage

//--- if_speedup_timeout_and_test_mux.sv
/*
   IF speed-up timeout counter and test/lock output selector.
   Assumes the serial shift logic hands over whole 24-bit words with a
   one-cycle strobe, and that PFD events, lock levels and divider
   pulses arrive synchronous to sys_clk.
*/
`timescale 1ns/100ps
module if_speedup_timeout_and_test_mux
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic word_valid,
   input wire logic [23:0] word_data,
   input wire logic if_pfd_event,
   input wire if_speedup_pkg::lock_inputs_type lock_inputs,
   input wire if_speedup_pkg::divider_pulses_type divider_pulses,
   output logic osc_or_speedup_pin_out,
   output logic osc_or_speedup_pin_oe,
   output logic if_pump_output_high_gain,
   output logic test_lock_pin_out,
   output logic test_lock_pin_oe
);
   import if_speedup_pkg::*;

   // ==========================================================
   // Decoding
   function automatic timeout_mode_type decode_mode
   (
      input logic [11:0] toc
   );
      timeout_mode_type m;
      unique case (toc)
         toc_tristate: m = mode_tristate;
         toc_manual: m = mode_manual;
         toc_gpo_low: m = mode_gpo_low;
         toc_gpo_high: m = mode_gpo_high;
         default: m = mode_auto;
      endcase
      return m;
   endfunction

   // Open drain: released (pulled high) when locked, else pulled low
   function automatic pin_drive_type open_drain
   (
      input logic level
   );
      pin_drive_type p;
      p.out = 1'b0;
      p.oe = ~level;
      return p;
   endfunction

   function automatic pin_drive_type push_pull
   (
      input logic level
   );
      pin_drive_type p;
      p.out = level;
      p.oe = 1'b1;
      return p;
   endfunction

   // ==========================================================
   // State
   state_type st;
   state_type next_st;
   timeout_mode_type next_mode;
   logic auto_running;
   logic [2:0] word_addr;
   logic rf_ana_both;
   logic dig_both;

   assign word_addr = word_data[addr_msb:addr_lsb];

   always_comb
   begin
      next_st = st;
      next_mode = mode_tristate;
      auto_running = 1'b0;
      dig_both = lock_inputs.rf_digital & lock_inputs.if_digital;
      rf_ana_both = lock_inputs.rf_analog & lock_inputs.if_analog;

      // PFD event first, so a write in the same cycle stays pending
      if (if_pfd_event)
      begin
         if (st.pending_flag)
         begin
            next_st.if_timeout_count = st.pending_timeout;
            next_st.period_count = 12'h000;
            next_st.pending_flag = 1'b0;
         end
         else if (st.period_count < st.if_timeout_count)
         begin
            next_st.period_count = 12'(st.period_count + 12'h001);
         end
      end

      // Word intake; upper data bits of the timeout word are ignored
      if (word_valid)
      begin
         unique case (word_addr)
            addr_timeout_word:
            begin
               next_st.pending_timeout =
                  word_data[timeout_msb:timeout_lsb];
               next_st.pending_flag = 1'b1;
            end
            addr_gain_word:
            begin
               next_st.if_pump_gain = word_data[gain_bit];
               next_st.select_high =
                  word_data[select_msb:select_lsb];
            end
            addr_select_low:
            begin
               next_st.select_low =
                  word_data[select_msb:select_lsb];
            end
            default:
            begin
               next_st.select_low = st.select_low;
            end
         endcase
      end

      // Divide-by-two toggles, one per divider output
      for (int i = 0; i < 4; i++)
      begin
         if (divider_pulses[i])
         begin
            next_st.halves[i] = ~st.halves[i];
         end
      end

      // Speed-up pin and pump gain from the latched timeout
      next_mode = decode_mode(next_st.if_timeout_count);
      auto_running = next_st.period_count < next_st.if_timeout_count;
      next_st.pump_high = next_st.if_pump_gain;
      unique case (next_mode)
         mode_tristate:
         begin
            next_st.speedup_pin = '{out: 1'b0, oe: 1'b0};
         end
         mode_manual:
         begin
            next_st.speedup_pin = '{out: 1'b0, oe: 1'b1};
            next_st.pump_high = 1'b1;
         end
         mode_gpo_low:
         begin
            next_st.speedup_pin = '{out: 1'b0, oe: 1'b1};
         end
         mode_gpo_high:
         begin
            next_st.speedup_pin = '{out: 1'b1, oe: 1'b1};
         end
         mode_auto:
         begin
            if (auto_running)
            begin
               next_st.speedup_pin = '{out: 1'b0, oe: 1'b1};
               next_st.pump_high = 1'b1;
            end
            else
            begin
               next_st.speedup_pin = '{out: 1'b0, oe: 1'b0};
               next_st.pump_high = 1'b0;
            end
         end
      endcase

      // Test/lock pin selector
      unique case ({next_st.select_high, next_st.select_low})
         sel_tristate: next_st.test_pin = '{out: 1'b0, oe: 1'b0};
         sel_high: next_st.test_pin = push_pull(1'b1);
         sel_low: next_st.test_pin = push_pull(1'b0);
         sel_dig_both: next_st.test_pin = open_drain(dig_both);
         sel_dig_rf:
            next_st.test_pin = open_drain(lock_inputs.rf_digital);
         sel_dig_if:
            next_st.test_pin = open_drain(lock_inputs.if_digital);
         sel_ana_od_both:
            next_st.test_pin = open_drain(rf_ana_both);
         sel_ana_od_rf:
            next_st.test_pin = open_drain(lock_inputs.rf_analog);
         sel_ana_od_if:
            next_st.test_pin = open_drain(lock_inputs.if_analog);
         sel_ana_pp_both:
            next_st.test_pin = push_pull(rf_ana_both);
         sel_ana_pp_rf:
            next_st.test_pin = push_pull(lock_inputs.rf_analog);
         sel_ana_pp_if:
            next_st.test_pin = push_pull(lock_inputs.if_analog);
         sel_if_ref_half:
            next_st.test_pin = push_pull(next_st.halves[0]);
         sel_if_fb_half:
            next_st.test_pin = push_pull(next_st.halves[1]);
         sel_rf_ref_half:
            next_st.test_pin = push_pull(next_st.halves[2]);
         sel_rf_fb_half:
            next_st.test_pin = push_pull(next_st.halves[3]);
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         st.pending_timeout <= timeout_reset;
         st.pending_flag <= 1'b0;
         st.if_timeout_count <= timeout_reset;
         st.period_count <= timeout_reset;
         st.if_pump_gain <= gain_reset;
         st.select_high <= select_reset;
         st.select_low <= select_reset;
         st.halves <= 4'h0;
         st.speedup_pin <= '{out: 1'b0, oe: 1'b0};
         st.test_pin <= '{out: 1'b0, oe: 1'b0};
         st.pump_high <= gain_reset;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign osc_or_speedup_pin_out = st.speedup_pin.out;
   assign osc_or_speedup_pin_oe = st.speedup_pin.oe;
   assign if_pump_output_high_gain = st.pump_high;
   assign test_lock_pin_out = st.test_pin.out;
   assign test_lock_pin_oe = st.test_pin.oe;

endmodule

//--- if_speedup_sva.sv
/* Checker for speed-up and test pin outputs.
   Bound to the top module, sees its ports only. */
`timescale 1ns/100ps
module if_speedup_sva
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic word_valid,
   input wire logic [23:0] word_data,
   input wire logic if_pfd_event,
   input wire if_speedup_pkg::lock_inputs_type lock_inputs,
   input wire if_speedup_pkg::divider_pulses_type divider_pulses,
   input wire logic osc_or_speedup_pin_out,
   input wire logic osc_or_speedup_pin_oe,
   input wire logic if_pump_output_high_gain,
   input wire logic test_lock_pin_out,
   input wire logic test_lock_pin_oe
);
   import if_speedup_pkg::*;
   logic [11:0] pend, toc;
   logic pf, gain, lk;
   logic [3:0] sel;
   logic [1:0] age;
   wire logic [2:0] ad = word_data[2:0];
   wire logic w5 = word_valid && ad == addr_timeout_word;
   // ==========================================
   // Shadow of settings, age counts quiet edges
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pend <= '0;
         toc <= '0;
         pf <= 1'b0;
         gain <= 1'b0;
         sel <= '0;
         age <= '0;
      end
      else if (!ce)
         age <= '0;
      else
      begin
         age <= (word_valid && ad inside {3'h0, 3'h3}) ? 2'h0 :
            (age == 2'h3 ? age : age + 2'h1);
         if (word_valid && ad == addr_gain_word)
         begin
            gain <= word_data[gain_bit];
            sel[3:2] <= word_data[23:22];
         end
         if (word_valid && ad == addr_select_low)
            sel[1:0] <= word_data[23:22];
         // Event latches the older word; a write in that cycle stays pending
         if (if_pfd_event && pf)
         begin
            toc <= pend;
            pf <= 1'b0;
         end
         if (w5)
         begin
            pend <= word_data[14:3];
            pf <= 1'b1;
         end
      end
   end
   wire logic dg = sel < 4'h6;
   wire logic r = dg ? lock_inputs.rf_digital : lock_inputs.rf_analog;
   wire logic i = dg ? lock_inputs.if_digital : lock_inputs.if_analog;
   always_comb
   begin
      case ((sel - 4'h3) % 4'h3)
         4'h0: lk = r && i;
         4'h1: lk = r;
         default: lk = i;
      endcase
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Properties
   property p_sel_fixed;
      age > 2'h1 && sel < 4'h3 |-> test_lock_pin_oe == (sel != 4'h0)
         && (sel == 4'h0 || test_lock_pin_out == (sel == 4'h1));
   endproperty
   a_sel_fixed: assert property (p_sel_fixed)
      else $error("static test pin wrong");
   property p_open_drain;
      age > 2'h1 && sel inside {[4'h3:4'h8]} |->
         !test_lock_pin_out && test_lock_pin_oe == !$past(lk);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open drain lock wrong");
   property p_push_pull;
      age > 2'h1 && sel inside {[4'h9:4'hb]} |->
         test_lock_pin_oe && test_lock_pin_out == $past(lk);
   endproperty
   a_push_pull: assert property (p_push_pull)
      else $error("push-pull lock wrong");
   property p_half;
      age == 2'h3 && sel > 4'hb && !$past(divider_pulses[sel[1:0]])
         && !$past(divider_pulses[sel[1:0]], 2) |->
         test_lock_pin_oe && $stable(test_lock_pin_out);
   endproperty
   a_half: assert property (p_half)
      else $error("halved output moved without pulse");
   property p_toc_pin;
      toc < 12'h4 && $stable(toc) |->
         osc_or_speedup_pin_oe == (toc != 12'h0)
         && osc_or_speedup_pin_out == (toc == 12'h3);
   endproperty
   a_toc_pin: assert property (p_toc_pin)
      else $error("speed-up pin static mode wrong");
   property p_toc_gain;
      toc < 12'h4 && $stable(toc) && $stable(gain) |->
         if_pump_output_high_gain == (toc == 12'h1 || gain);
   endproperty
   a_toc_gain: assert property (p_toc_gain)
      else $error("pump gain wrong in static mode");
   property p_pin_hold;
      !(ce && if_pfd_event) |=>
         $stable({osc_or_speedup_pin_out, osc_or_speedup_pin_oe});
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("speed-up pin moved without event");
   property p_auto_start;
      toc > 12'h3 && $changed(toc) |-> osc_or_speedup_pin_oe
         && !osc_or_speedup_pin_out && if_pump_output_high_gain;
   endproperty
   a_auto_start: assert property (p_auto_start)
      else $error("automatic period not started");
   property p_auto_end;
      toc > 12'h3 && !osc_or_speedup_pin_oe |-> !if_pump_output_high_gain;
   endproperty
   a_auto_end: assert property (p_auto_end)
      else $error("gain high after expiry");
endmodule
bind if_speedup_timeout_and_test_mux if_speedup_sva if_speedup_sva_inst
(
   .sys_clk(sys_clk), .rst(rst), .ce(ce), .word_valid(word_valid),
   .word_data(word_data), .if_pfd_event(if_pfd_event),
   .lock_inputs(lock_inputs), .divider_pulses(divider_pulses),
   .osc_or_speedup_pin_out(osc_or_speedup_pin_out),
   .osc_or_speedup_pin_oe(osc_or_speedup_pin_oe),
   .if_pump_output_high_gain(if_pump_output_high_gain),
   .test_lock_pin_out(test_lock_pin_out),
   .test_lock_pin_oe(test_lock_pin_oe)
);

//--- host_writer.sv
/* Host model handing whole programming words to the block.
   Callers enter send just after a rising edge. */
`timescale 1ns/100ps
module host_writer
(
   input wire logic sys_clk,
   output logic word_valid,
   output logic [23:0] word_data
);
   initial
   begin
      word_valid = 1'b0;
      word_data = 24'h0;
   end
   // Idle gap after each word keeps strobes apart
   task automatic send(input logic [2:0] a, input logic [20:0] d);
      word_valid = 1'b1;
      word_data = {d, a};
      @(posedge sys_clk);
      #1;
      word_valid = 1'b0;
      word_data = ~word_data;
      @(posedge sys_clk);
      #1;
   endtask
endmodule

//--- testbench.sv
/* Self-checking bench for the speed-up and test pin block.
   Uses host_writer for words; checker is bound. */
`timescale 1ns/100ps
module testbench;
   import if_speedup_pkg::*;
   logic sys_clk, rst, ce, pfd_in, wv, sp_out, sp_oe, g_hi, tp_out, tp_oe;
   lock_inputs_type lock_in;
   divider_pulses_type div_in;
   logic [23:0] wd;
   int n_mismatch, comparisons;
   host_writer host_writer_inst (.sys_clk(sys_clk), .word_valid(wv),
      .word_data(wd));
   if_speedup_timeout_and_test_mux if_speedup_timeout_and_test_mux_inst
   (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .word_valid(wv),
      .word_data(wd), .if_pfd_event(pfd_in), .lock_inputs(lock_in),
      .divider_pulses(div_in), .osc_or_speedup_pin_out(sp_out),
      .osc_or_speedup_pin_oe(sp_oe), .if_pump_output_high_gain(g_hi),
      .test_lock_pin_out(tp_out), .test_lock_pin_oe(tp_oe)
   );
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task pfd;
      pfd_in = 1'b1;
      step(1);
      pfd_in = 1'b0;
      step(1);
   endtask
   task set_sel(input logic [3:0] s, input logic g);
      host_writer_inst.send(3'h3, {s[3:2], 2'h0, g, 16'h0});
      host_writer_inst.send(3'h0, {s[1:0], 19'h0});
   endtask
   task set_toc(input logic [11:0] t);
      host_writer_inst.send(3'h5, {9'h0, t});
   endtask
   task t_static;
      logic [1:0] p;
      for (int g = 0; g < 2; g++)
         for (int t = 0; t < 4; t++)
         begin
            set_sel(4'h0, g[0]);
            p = {sp_oe, sp_out};
            set_toc(t[11:0]);
            chk({2'b0, sp_oe, sp_out}, {2'b0, p}, "pin before event");
            pfd;
            chk({1'b0, sp_oe, sp_out, g_hi}, {1'b0, t != 0, t == 3,
               t == 1 || g == 1}, "static mode");
         end
      $display("test static done");
   endtask
   task t_auto(input logic [11:0] n);
      set_toc(n);
      pfd;
      for (int i = 1; i < n; i++)
         pfd;
      chk({1'b0, sp_oe, sp_out, g_hi}, 4'h5, "auto running");
      pfd;
      chk({1'b0, sp_oe, sp_out, g_hi}, 4'h0, "auto expired");
      $display("test auto done");
   endtask
   task t_restart;
      set_toc(12'h006);
      repeat (3) pfd;
      t_auto(12'h004);
   endtask
   function automatic logic [1:0] exp_tp(input logic [3:0] s,
      input lock_inputs_type l);
      logic r, i, k;
      r = s < 6 ? l.rf_digital : l.rf_analog;
      i = s < 6 ? l.if_digital : l.if_analog;
      k = (s - 3) % 3 == 0 ? r && i : ((s - 3) % 3 == 1 ? r : i);
      if (s < 3)
         return s == 0 ? 2'b00 : {1'b1, s == 1};
      return s < 9 ? {!k, 1'b0} : {1'b1, k};
   endfunction
   task t_select;
      // 9 and 6 split digital from analog lock levels
      logic [3:0] pats [5] = '{4'hf, 4'h0, 4'ha, 4'h9, 4'h6};
      logic v;
      for (int s = 0; s < 12; s++)
         foreach (pats[p])
         begin
            set_sel(s[3:0], 1'b0);
            lock_in = pats[p];
            step(2);
            chk({2'b0, tp_oe, tp_out}, {2'b0, exp_tp(s[3:0], pats[p])},
               "test pin");
         end
      for (int s = 12; s < 16; s++)
      begin
         set_sel(s[3:0], 1'b0);
         step(2);
         v = tp_out;
         div_in = ~(4'h1 << (s - 12));
         step(1);
         div_in = '0;
         step(2);
         chk({2'b0, tp_oe, tp_out}, {3'b001, v}, "other divider");
         div_in[s - 12] = 1'b1;
         step(1);
         div_in = '0;
         step(2);
         chk({2'b0, tp_oe, tp_out}, {3'b001, !v}, "halved toggle");
      end
      $display("test select done");
   endtask
   task t_freeze;
      set_toc(12'h003);
      ce = 1'b0;
      pfd;
      chk({2'b0, sp_oe, sp_out}, 4'h0, "frozen by enable");
      ce = 1'b1;
      pfd;
      chk({2'b0, sp_oe, sp_out}, 4'h3, "after enable");
      $display("test freeze done");
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      pfd_in = 1'b0;
      lock_in = '0;
      div_in = '0;
      n_mismatch = 0;
      comparisons = 0;
      step(8);
      rst = 1'b0;
      step(1);
      chk({1'b0, sp_oe, g_hi, tp_oe}, 4'h0, "after reset");
      t_static;
      t_auto(12'h004);
      t_restart;
      t_auto(12'hfff);
      t_freeze;
      t_select;
      end_sim;
   end
endmodule
